// ### design/irr_pkg.sv
// irr_pkg: constants and types for the interrupt request registers
// assumes an apb slave with 32-bit data and word-aligned registers
package irr_pkg;

    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;
    localparam int          GRP_N         = 3;
    localparam int          SRC_W         = 5;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_TIMER_ADC = 12'hfc0;
    localparam logic [11:0] IDX_PORT_A    = 12'hfc3;
    localparam logic [11:0] IDX_PORT_C    = 12'hfc6;
    localparam logic [11:0] IDX_CONTROL   = 12'hfc8;
    localparam logic [11:0] IDX_EVT_STAT  = 12'hfc9;
    localparam logic [11:0] IDX_EVT_MASK  = 12'hfca;

    // bit positions
    localparam int          BIT_TIMER1    = 6;
    localparam int          BIT_TIMER0    = 5;
    localparam int          BIT_CONVERTER = 0;
    localparam int          BIT_PA_SHARED = 6;
    localparam int          BIT_ENABLE    = 0;

    // writable bit masks; other bits are reserved and read zero
    localparam logic [7:0]  WMASK_TIMER_ADC = 8'h61;
    localparam logic [7:0]  WMASK_PORT_A    = 8'hff;
    localparam logic [7:0]  WMASK_PORT_C    = 8'h0f;

    localparam logic [7:0]  RST_REQ       = 8'h00;
    localparam logic [2:0]  RST_EVT       = 3'h0;

    typedef enum logic [2:0] {
        IRR_SEL_NONE  = 3'b000,
        IRR_SEL_REQ0  = 3'b001,
        IRR_SEL_REQ1  = 3'b010,
        IRR_SEL_REQ2  = 3'b011,
        IRR_SEL_CTRL  = 3'b100,
        IRR_SEL_STAT  = 3'b101,
        IRR_SEL_MASK  = 3'b110
    } irr_sel_e;

    typedef struct packed {
        logic [GRP_N-1:0][REG_W-1:0] req;
        logic                        global_enable;
        logic [GRP_N-1:0]            evt_status;
        logic [GRP_N-1:0]            evt_mask;
        logic [DATA_W-1:0]           prdata;
    } irr_state_s;

endpackage

// ### design/irr_top.sv
// irr_top: three pending-request registers behind an apb slave
// assumes one-cycle request pulses synchronous to pclk and a core ack port
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps

// Overview of operation
// RULE_01: a request pulse sets its source bit, which stays set until cleared.
// RULE_02: with global enable on, pending requests go to the core.
// RULE_03: with global enable off, requests still latch and read back for polling.
// RULE_04: first register: timer1 bit 6, timer0 bit 5, converter bit 0.
// RULE_05: second register: port a pin n in bit n; bit 6 shared with comparator.
// RULE_06: third register: port c pins 3 to 0 in bits 3 to 0.
// RULE_07: a request bit reads 1 while pending, 0 otherwise.
// RULE_08: software writes zero to reserved bits of first and third registers.
// RULE_09: watchdog and oscillator-fail traps are not held in these registers.
// RULE_10: each source gives a one-cycle pulse which the register captures.
// RULE_11: a core acknowledge clears the acknowledged source's request bit; an APB write to the same register in that cycle wins and the ack is lost.
// RULE_12: software writing 0 to a request bit clears it.
// RULE_13: software writing 1 to a request bit raises a request.
// RULE_14: hardware set beats software clear in the same cycle.
module irr_top
    import irr_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              timer1_pulse,
    input  wire logic              timer0_pulse,
    input  wire logic              converter_pulse,
    input  wire logic [7:0]        porta_pulse,
    input  wire logic              comparator_pulse,
    input  wire logic [3:0]        portc_pulse,
    input  wire logic              ack_valid,
    input  wire logic [SRC_W-1:0]  ack_source,
    output logic                   core_request,
    output logic [7:0]             timer_adc_request,
    output logic [7:0]             port_a_request,
    output logic [7:0]             port_c_request,
    output logic                   irq
);

    irr_state_s state;
    irr_state_s next_state;

    logic [GRP_N-1:0][REG_W-1:0] hw_set;
    logic [GRP_N-1:0][REG_W-1:0] ack_clr;
    logic [GRP_N-1:0][REG_W-1:0] wmask;
    irr_sel_e                    sel;
    logic                        wr_en;
    logic                        setup_en;
    logic [GRP_N-1:0][REG_W-1:0] req_next;

    // select code of a request group, used by the write path
    function automatic irr_sel_e grp_sel(input int g);
        case (g)
            0:       return IRR_SEL_REQ0;
            1:       return IRR_SEL_REQ1;
            2:       return IRR_SEL_REQ2;
            default: return IRR_SEL_NONE;
        endcase
    endfunction

    // address decode, used for both read and write
    function automatic irr_sel_e decode(input logic [ADDR_W-1:0] a);
        logic [11:0] idx;
        idx = a[13:2];
        if (a[1:0] != 2'h0 || a[ADDR_W-1:14] != 2'h0)
            return IRR_SEL_NONE;
        case (idx)
            IDX_TIMER_ADC: return IRR_SEL_REQ0;
            IDX_PORT_A:    return IRR_SEL_REQ1;
            IDX_PORT_C:    return IRR_SEL_REQ2;
            IDX_CONTROL:   return IRR_SEL_CTRL;
            IDX_EVT_STAT:  return IRR_SEL_STAT;
            IDX_EVT_MASK:  return IRR_SEL_MASK;
            default:       return IRR_SEL_NONE;
        endcase
    endfunction

    assign sel      = decode(paddr);
    assign wr_en    = psel && penable && pwrite && pstrb[0] && (sel != IRR_SEL_NONE);
    assign setup_en = psel && !penable;

    assign wmask[0] = WMASK_TIMER_ADC;
    assign wmask[1] = WMASK_PORT_A;
    assign wmask[2] = WMASK_PORT_C;

    // hardware request pulses mapped to bit positions
    always_comb
    begin
        hw_set = '0;
        hw_set[0][BIT_TIMER1]    = timer1_pulse;                        // RULE_04
        hw_set[0][BIT_TIMER0]    = timer0_pulse;                        // RULE_04
        hw_set[0][BIT_CONVERTER] = converter_pulse;                     // RULE_04
        hw_set[1]                = porta_pulse;                         // RULE_05
        hw_set[1][BIT_PA_SHARED] = porta_pulse[BIT_PA_SHARED] | comparator_pulse; // RULE_05
        hw_set[2]                = {4'h0, portc_pulse} & WMASK_PORT_C;  // RULE_06
    end

    // acknowledge decode: source = group * 8 + bit
    always_comb
    begin
        ack_clr = '0;
        if (ack_valid && ack_source[4:3] < 2'(GRP_N))
            ack_clr[ack_source[4:3]][ack_source[2:0]] = 1'b1;           // RULE_11
    end

    // per-group request update: write or ack, then hardware set on top
    for (genvar g = 0; g < GRP_N; g++)
    begin : g_req
        logic             wr_hit;
        logic [REG_W-1:0] kept;
        assign wr_hit      = wr_en && (sel == grp_sel(g));
        assign kept        = wr_hit ? (pwdata[REG_W-1:0] & wmask[g])    // RULE_12 RULE_13
                                    : (state.req[g] & ~ack_clr[g]);      // RULE_11
        assign req_next[g] = (kept | hw_set[g]) & wmask[g];             // RULE_01 RULE_10 RULE_14
    end

    always_comb
    begin
        next_state     = state;
        next_state.req = req_next;
        if (wr_en && sel == IRR_SEL_CTRL)
            next_state.global_enable = pwdata[BIT_ENABLE];
        if (wr_en && sel == IRR_SEL_MASK)
            next_state.evt_mask = pwdata[GRP_N-1:0];
        if (wr_en && sel == IRR_SEL_STAT)
            next_state.evt_status = state.evt_status & ~pwdata[GRP_N-1:0];
        for (int g = 0; g < GRP_N; g++)
            if (|hw_set[g])
                next_state.evt_status[g] = 1'b1;
        if (setup_en)
        begin
            next_state.prdata = '0;
            case (sel)
                IRR_SEL_REQ0: next_state.prdata[7:0] = state.req[0];   // RULE_03 RULE_07
                IRR_SEL_REQ1: next_state.prdata[7:0] = state.req[1];   // RULE_03 RULE_07
                IRR_SEL_REQ2: next_state.prdata[7:0] = state.req[2];   // RULE_03 RULE_07
                IRR_SEL_CTRL: next_state.prdata[BIT_ENABLE] = state.global_enable;
                IRR_SEL_STAT: next_state.prdata[GRP_N-1:0] = state.evt_status;
                IRR_SEL_MASK: next_state.prdata[GRP_N-1:0] = state.evt_mask;
                default:      next_state.prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state.req           <= {GRP_N{RST_REQ}};
            state.global_enable <= 1'b0;
            state.evt_status    <= RST_EVT;
            state.evt_mask      <= RST_EVT;
            state.prdata        <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // watchdog and oscillator traps have no bits here
    assign timer_adc_request = state.req[0];                            // RULE_09
    assign port_a_request    = state.req[1];
    assign port_c_request    = state.req[2];
    assign core_request      = state.global_enable && (|state.req);     // RULE_02
    assign irq               = |(state.evt_status & state.evt_mask);
    assign prdata            = state.prdata;
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && (sel == IRR_SEL_NONE);

endmodule // irr_top

// ### testbench/irr_core_model.sv
// irr_core_model: core acking lowest pending source
// assumes pend is {port c, port a, timer adc}
`timescale 1ns/100ps
module irr_core_model
    import irr_pkg::*;
(
    input wire logic        pclk, presetn, auto_ack, core_request,
    input wire logic [23:0] pend,
    output logic            ack_valid,
    output logic [SRC_W-1:0] ack_source
);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {ack_valid, ack_source} <= '0;
        else
        begin
            ack_valid <= auto_ack && core_request && !ack_valid;
            for (int i = 23; i >= 0; i--)
                if (pend[i]) ack_source <= SRC_W'(i);
        end
endmodule // irr_core_model

// ### testbench/irr_top_asserts.sv
// irr_top_asserts: port timing checks
// assumes one clock domain, bound into irr_top
`timescale 1ns/100ps
module irr_top_asserts
    import irr_pkg::*;
(
    input wire logic              pclk, presetn, psel, penable, pwrite, ack_valid,
    input wire logic              core_request, timer1_pulse, comparator_pulse,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0]        pstrb, portc_pulse,
    input wire logic [7:0]        porta_pulse, timer_adc_request, port_a_request,
    input wire logic [7:0]        port_c_request,
    input wire logic [SRC_W-1:0]  ack_source
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite && pstrb[0];
    a_timer1_set: assert property (timer1_pulse |=> timer_adc_request[6])
        else $error("timer1 lost");
    a_cmp_set: assert property (comparator_pulse |=> port_a_request[6])
        else $error("comparator lost");
    a_portc_set: assert property (portc_pulse[3] |=> port_c_request[3])
        else $error("port c lost");
    a_adc_hold: assert property ($fell(timer_adc_request[0]) |-> $past(wr || ack_valid))
        else $error("adc dropped");
    a_core_pend: assert property (core_request |-> |{port_c_request, port_a_request,
        timer_adc_request}) else $error("core request idle");
    a_ack_clear: assert property (ack_valid && ack_source == 5'd8 && !porta_pulse[0]
        && !wr |=> !port_a_request[0]) else $error("ack kept bit");
    a_wr_clear: assert property (wr && paddr == 16'h3f0c && !pwdata[1]
        && !porta_pulse[1] |=> !port_a_request[1]) else $error("write kept bit");
    a_rsvd_zero: assert property (!(timer_adc_request & 8'h9e) && !port_c_request[7:4])
        else $error("reserved set");
    cover property (wr && porta_pulse != 8'h00);
    cover property (ack_valid);
    cover property (core_request);
endmodule // irr_top_asserts
bind irr_top irr_top_asserts irr_top_asserts_inst (.*);

// ### testbench/tb_irr_top.sv
// tb_irr_top: random and corner tests over apb
// assumes irr_core_model as core, checker bound
`timescale 1ns/100ps
module tb_irr_top;
    import irr_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, auto_ack = 0;
    logic [15:0] paddr = 0, src = 0, v;
    logic [31:0] pwdata = 0, rd, prdata;
    logic [3:0]  pstrb = 4'hf, portc_pulse;
    logic [7:0]  porta_pulse, timer_adc_request, port_a_request, port_c_request;
    logic        timer1_pulse, timer0_pulse, converter_pulse, comparator_pulse;
    logic        pready, pslverr, err, ack_valid, core_request, irq;
    logic [SRC_W-1:0] ack_source;
    logic [23:0] ex;
    int          seed = 32'he5b41bfb, n_mismatch = 0, check_count = 0;
    localparam logic [11:0] IX [3] = '{IDX_TIMER_ADC, IDX_PORT_A, IDX_PORT_C};
    localparam logic [7:0]  WM [3] = '{WMASK_TIMER_ADC, WMASK_PORT_A, WMASK_PORT_C};
    assign {timer1_pulse, timer0_pulse, converter_pulse, porta_pulse, comparator_pulse,
        portc_pulse} = src;
    irr_top irr_top_inst (.*);
    irr_core_model irr_core_model_inst (.*, .pend({port_c_request, port_a_request,
        timer_adc_request}));
    initial forever #10 pclk = ~pclk;
    initial
    begin
        #400000 n_mismatch++;
        tally_and_finish;
    end
    function automatic logic [15:0] ba(logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    function automatic logic [23:0] fold(logic [15:0] p);
        return {4'h0, p[3:0], p[12:5] | {1'b0, p[4], 6'h0}, 1'b0, p[15:14], 4'h0, p[13]};
    endfunction
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rdall(input logic [23:0] e);
        for (int g = 0; g < 3; g++)
        begin
            apb(0, ba(IX[g]), 0);
            chk(rd, e[8*g+:8]);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        rdall(24'h0);
        ex = 0;
        repeat (30)
        begin
            v = $random(seed);
            @(posedge pclk) src <= v;
            @(posedge pclk) src <= 0;
            ex |= fold(v);
        end
        rdall(ex);
        chk(core_request, 0);
        apb(0, ba(IDX_EVT_STAT), 0);
        chk(rd, {|ex[23:16], |ex[15:8], |ex[7:0]});
        apb(1, ba(IDX_EVT_MASK), 7);
        @(negedge pclk) chk(irq, |ex);
        apb(1, ba(IDX_EVT_STAT), 7);
        @(negedge pclk) chk(irq, 0);
        $display("test latch done");
        for (int g = 0; g < 3; g++)
        begin
            apb(1, ba(IX[g]), WM[g]);
            apb(0, ba(IX[g]), 0);
            chk(rd, WM[g]);
            apb(1, ba(IX[g]), 0);
            apb(0, ba(IX[g]), 0);
            chk(rd, 0);
        end
        fork
            apb(1, ba(IDX_PORT_A), 0);
            @(posedge pclk) @(posedge pclk) src <= 16'h0020;
        join
        src <= 0;
        apb(1, ba(IX[0]), 32'h61);
        apb(1, ba(IDX_CONTROL), 1);
        @(negedge pclk) chk(port_a_request, 8'h01);
        chk(core_request, 1);
        @(posedge pclk) auto_ack <= 1;
        repeat (12) @(posedge pclk);
        @(negedge pclk) chk({port_c_request, port_a_request, timer_adc_request}, 0);
        apb(0, 16'h3f01, 0);
        chk(err, 1);
        chk(rd, 0);
        $display("test write and ack done");
        tally_and_finish;
    end
endmodule // tb_irr_top
